/* File: core/shadow_cfg.svh */
// Purpose: constants for the fast-side shadow and mirror control block
// Assumes: 24-bit cpu address, bank in bits 23:16, 8-bit data
// Notes: offsets are 16-bit addresses inside an i/o-enabled bank
//
// How it works
// - fast side runs fast; slow side keeps its own 1 MHz phase
// - i/o or slow-bank access waits for slow phase, then resumes fast
// - duplicated soft switches follow writes, lc bank slot also reads; reads go to slow side
// - soft switches decode only in shadow-enabled bank with io inhibit clear
// - state register reads run fast; writes take one slow cycle
// - state register writes also forwarded to slow copy; reads stay local
// - shadowed writes go to fast bank and slow bank E0 or E1
// - config bit 4 set shadows banks 00-7F, clear only 00 and 01
// - direct access to slow banks always allowed, never blocked
// - shadow bit 6 clear maps Cxxx as i/o plus second D bank
// - shadow bit 4 suppresses hi-res shadowing in odd banks only
// - shadow bit 3 disables shadowing of whole 32K video buffer
// - hi-res page 2 inhibit bit stops main and aux page 2 shadowing
// - hi-res page 1 inhibit bit stops main and aux page 1 shadowing
// - shadow bit 0 disables main and aux text page 1 shadowing
// - text page 2, 0800 to 0BFF, is never shadowed
// - shadow bits active high; shadow register cleared on reset
// - all shadow bits set stops all shadowing
// - configuration register cleared on reset
`ifndef SHADOW_CFG_SVH
`define SHADOW_CFG_SVH

// register offsets
`define SHADOW_REG_OFFSET 16'hc035
`define CONFIG_REG_OFFSET 16'hc036
`define STATE_REG_OFFSET 16'hc068

// reset values
`define SHADOW_RESET 8'h00
`define CONFIG_RESET 8'h00
`define STATE_RESET 8'h00

// shadow register fields
`define SHD_TEXT1_BIT 0
`define SHD_HIRES1_BIT 1
`define SHD_HIRES2_BIT 2
`define SHD_VIDBUF_BIT 3
`define SHD_AUXHIRES_BIT 4
`define SHD_IO_LANGCARD_INHIBIT_BIT 6

// configuration register fields
`define CFG_SCOPE_BIT 4
`define CFG_SPEED_BIT 7

// address areas
`define IO_PAGE 4'hc
`define DPAGE 4'hd
`define TEXT1_TOP 6'h01
`define TEXT2_TOP 6'h02
`define HIRES1_TOP 3'h1
`define HIRES2_TOP 3'h2
`define VIDBUF_LO 3'h1
`define VIDBUF_HI 3'h4
`define LOW_BANKS_MAX 8'h01
`define FAST_BANKS_MAX 8'h7f
`define SLOW_BANK_MAIN 8'he0
`define SLOW_BANK_AUX 8'he1
`define LC_SWITCH_PAGE 12'hc08

// soft switch slots
`define SW_COUNT 7
`define SW_LC_BANK1 6

`endif

/* File: core/shadow_pkg.sv */
// Purpose: shared types of the fast-side shadow control block
// Assumes: nothing beyond the constants header
// Notes: states carry no codes
package shadow_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FAST,
    ST_CATCH,
    ST_ALIGN,
    ST_SLOW
  } seq_state_e;
  typedef logic [7:0] byte_t;
endpackage

/* File: core/pin_sync.sv */
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs may change at any time relative to clk
// Notes: first stage feeds only the second stage
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // data
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] synced
);
  initial begin
    if (WIDTH < 1) $error("pin_sync width must be positive");
  end
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
    end
  end
  assign synced = sync_q;
endmodule

/* File: core/shadow_decode.sv */
// Purpose: decides bank scope, i/o decode and area shadowing of an access
// Assumes: bank and offset come from the cpu request
// Notes: purely combinational
`include "shadow_cfg.svh"
module shadow_decode
  import shadow_pkg::*;
(
  // access
  input wire logic [7:0] bank,
  input wire logic [15:0] offset,
  // control
  input wire byte_t shadow,
  input wire logic scope_all,
  // results
  output logic bank_shadowed,
  output logic io_space,
  output logic area_shadowed,
  output logic slow_direct
);
  logic aux;
  logic text1;
  logic text2;
  logic hires1;
  logic hires2;
  logic vidbuf;
  logic hires_ok;
  always_comb begin
    aux = bank[0];
    bank_shadowed = scope_all ? (bank <= `FAST_BANKS_MAX)
                              : (bank <= `LOW_BANKS_MAX);
    io_space = bank_shadowed && !shadow[`SHD_IO_LANGCARD_INHIBIT_BIT]
               && (offset[15:12] == `IO_PAGE);
    slow_direct = (bank == `SLOW_BANK_MAIN) || (bank == `SLOW_BANK_AUX);
    text1 = (offset[15:10] == `TEXT1_TOP);
    text2 = (offset[15:10] == `TEXT2_TOP);
    hires1 = (offset[15:13] == `HIRES1_TOP);
    hires2 = (offset[15:13] == `HIRES2_TOP);
    vidbuf = (offset[15:13] >= `VIDBUF_LO) && (offset[15:13] <= `VIDBUF_HI);
    hires_ok = !(aux && shadow[`SHD_AUXHIRES_BIT]);
    area_shadowed = 1'b0;
    if (text1 && !shadow[`SHD_TEXT1_BIT]) area_shadowed = 1'b1;
    if (hires1) area_shadowed = !shadow[`SHD_HIRES1_BIT] && hires_ok;
    if (hires2) area_shadowed = !shadow[`SHD_HIRES2_BIT] && hires_ok;
    if (vidbuf && shadow[`SHD_VIDBUF_BIT]) area_shadowed = 1'b0;
    if (vidbuf && !hires1 && !hires2) begin
      area_shadowed = !shadow[`SHD_VIDBUF_BIT];
    end
    if (text2) area_shadowed = 1'b0;
    if (!bank_shadowed || (shadow == 8'hff)) area_shadowed = 1'b0;
  end
endmodule

/* File: core/fast_shadow_ctl.sv */
// Purpose: fast-side shadow, mirror and slow-cycle control
// Assumes: one request at a time held until cpu_ready; sync fast ram
// Notes: slow_phase is the slow side's cycle clock, sampled as a pin
`include "shadow_cfg.svh"
module fast_shadow_ctl
  import shadow_pkg::*;
#(
  parameter int ADDR_W = 24,
  parameter int SLOW_ADDR_W = 17
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // cpu request
  input wire logic cpu_valid,
  input wire logic cpu_we,
  input wire logic [ADDR_W-1:0] cpu_addr,
  input wire byte_t cpu_wdata,
  output logic cpu_ready,
  output byte_t cpu_rdata,
  // fast ram
  output logic fram_en,
  output logic fram_we,
  output logic [ADDR_W-1:0] fram_addr,
  output byte_t fram_wdata,
  input wire byte_t fram_rdata,
  // slow side
  input wire logic slow_phase,
  output logic slow_req,
  output logic slow_we,
  output logic [SLOW_ADDR_W-1:0] slow_addr,
  output byte_t slow_wdata,
  input wire byte_t slow_rdata,
  // status
  output logic fast_speed,
  output logic [`SW_COUNT-1:0] softsw_state,
  output byte_t switch_state
);
  initial begin
    if (ADDR_W != 24) $error("cpu address must be 24 bits");
    if (SLOW_ADDR_W != 17) $error("slow address must be 17 bits");
    if (`SW_LC_BANK1 >= `SW_COUNT) $error("lc bank slot outside copies");
    if (`SHD_IO_LANGCARD_INHIBIT_BIT > 7) $error("io inhibit bit outside shadow register");
  end

  // pin inputs
  logic phase_s;
  byte_t slow_rdata_s;
  pin_sync #(.WIDTH(1)) u_phase_sync (
    .clk(clk),
    .reset(reset),
    .pin(slow_phase),
    .synced(phase_s)
  );
  pin_sync #(.WIDTH(8)) u_data_sync (
    .clk(clk),
    .reset(reset),
    .pin(slow_rdata),
    .synced(slow_rdata_s)
  );

  // state
  seq_state_e state_q, state_d;
  byte_t shadow_q, shadow_d;
  byte_t config_q, config_d;
  byte_t mirror_q, mirror_d;
  logic [`SW_COUNT-1:0] softsw_q, softsw_d;
  byte_t rdata_q, rdata_d;
  logic ready_q, ready_d;
  logic fram_en_q, fram_en_d;
  logic fram_we_q, fram_we_d;
  logic [ADDR_W-1:0] fram_addr_q, fram_addr_d;
  byte_t fram_wdata_q, fram_wdata_d;
  logic slow_req_q, slow_req_d;
  logic slow_we_q, slow_we_d;
  logic [SLOW_ADDR_W-1:0] slow_addr_q, slow_addr_d;
  byte_t slow_wdata_q, slow_wdata_d;
  logic then_slow_q, then_slow_d;
  logic drive_q, drive_d;
  logic from_slow_q, from_slow_d;
  logic phase_prev_q, phase_prev_d;
  // tick gating and registered speed status
  logic [1:0] settle_q, settle_d;
  logic speed_q, speed_d;

  // request decode
  logic [7:0] bank;
  logic [15:0] offset;
  logic bank_shadowed;
  logic io_space;
  logic area_shadowed;
  logic slow_direct;
  logic take;
  logic tick;
  logic hit_shadow;
  logic hit_config;
  logic hit_mirror;
  logic hit_lc;
  logic sw_hit;
  logic [2:0] sw_idx;
  logic paced;
  logic [15:0] fram_off;
  logic [SLOW_ADDR_W-1:0] slow_target;

  assign bank = cpu_addr[23:16];
  assign offset = cpu_addr[15:0];

  shadow_decode u_decode (
    .bank(bank),
    .offset(offset),
    .shadow(shadow_q),
    .scope_all(config_q[`CFG_SCOPE_BIT]),
    .bank_shadowed(bank_shadowed),
    .io_space(io_space),
    .area_shadowed(area_shadowed),
    .slow_direct(slow_direct)
  );

  // soft switch slot from a write address
  always_comb begin
    sw_hit = 1'b0;
    sw_idx = 3'd0;
    if (io_space) begin
      unique casez (offset)
        16'hc00?: begin
          sw_hit = (offset[3:1] != 3'd3) && (offset[3:1] < 3'd5);
          sw_idx = (offset[3:1] == 3'd4) ? 3'd3 : offset[3:1];
        end
        16'hc05?: begin
          sw_hit = (offset[3:2] == 2'd1);
          sw_idx = offset[1] ? 3'd5 : 3'd4;
        end
        default: begin
          sw_hit = 1'b0;
          sw_idx = 3'd0;
        end
      endcase
    end
  end

  always_comb begin
    // the synchroniser refills after reset; its first rise is no tick
    tick = phase_s && !phase_prev_q
           && (settle_q == 2'd3);
    take = cpu_valid && !ready_q && (state_q == ST_IDLE);
    hit_shadow = io_space && (offset == `SHADOW_REG_OFFSET);
    hit_config = io_space && (offset == `CONFIG_REG_OFFSET);
    hit_mirror = io_space && (offset == `STATE_REG_OFFSET);
    hit_lc = io_space && (offset[15:4] == `LC_SWITCH_PAGE);
    paced = !config_q[`CFG_SPEED_BIT];
    // second D bank sits in the ram displaced by the i/o page
    fram_off = offset;
    if (bank_shadowed && !shadow_q[`SHD_IO_LANGCARD_INHIBIT_BIT]
        && (offset[15:12] == `DPAGE) && softsw_q[`SW_LC_BANK1]) begin
      fram_off = {`IO_PAGE, offset[11:0]};
    end
    slow_target = {bank[0], offset};
  end

  // sequencer and registers
  always_comb begin
    state_d = state_q;
    shadow_d = shadow_q;
    config_d = config_q;
    mirror_d = mirror_q;
    softsw_d = softsw_q;
    rdata_d = rdata_q;
    ready_d = 1'b0;
    fram_en_d = 1'b0;
    fram_we_d = 1'b0;
    fram_addr_d = fram_addr_q;
    fram_wdata_d = fram_wdata_q;
    slow_req_d = slow_req_q;
    slow_we_d = slow_we_q;
    slow_addr_d = slow_addr_q;
    slow_wdata_d = slow_wdata_q;
    then_slow_d = then_slow_q;
    drive_d = drive_q;
    from_slow_d = from_slow_q;
    phase_prev_d = phase_s;
    settle_d = (settle_q == 2'd3) ? settle_q : settle_q + 2'd1;
    unique case (state_q)
      // wait for a request and route it
      ST_IDLE: begin
        if (take) begin
          slow_we_d = cpu_we;
          slow_addr_d = slow_target;
          slow_wdata_d = cpu_wdata;
          if (hit_shadow) begin
            // shadow and config registers answer at once and are not forwarded
            if (cpu_we) shadow_d = cpu_wdata;
            rdata_d = shadow_q;
            ready_d = 1'b1;
          end else if (hit_config) begin
            if (cpu_we) config_d = cpu_wdata;
            rdata_d = config_q;
            ready_d = 1'b1;
          end else if (hit_mirror) begin
            if (cpu_we) begin
              mirror_d = cpu_wdata;
              drive_d = 1'b1;
              from_slow_d = 1'b0;
              state_d = ST_ALIGN;
            end else begin
              rdata_d = mirror_q;
              ready_d = 1'b1;
            end
          end else if (io_space) begin
            // copies follow writes; the slow side answers reads
            if (cpu_we && sw_hit) begin
              softsw_d[sw_idx] = offset[0];
            end
            if (hit_lc) begin
              softsw_d[`SW_LC_BANK1] = offset[3];
            end
            drive_d = 1'b1;
            from_slow_d = !cpu_we;
            state_d = ST_ALIGN;
          end else if (slow_direct) begin
            slow_addr_d = {bank[0], offset};
            drive_d = 1'b1;
            from_slow_d = !cpu_we;
            state_d = ST_ALIGN;
          end else begin
            // plain ram; shadowed writes then copy to the slow side
            fram_en_d = 1'b1;
            fram_we_d = cpu_we;
            fram_addr_d = {bank, fram_off};
            fram_wdata_d = cpu_wdata;
            drive_d = cpu_we && area_shadowed;
            then_slow_d = (cpu_we && area_shadowed) || paced;
            from_slow_d = 1'b0;
            state_d = ST_FAST;
          end
        end
      end

      // ram access issued; data follows next cycle
      ST_FAST: begin
        state_d = ST_CATCH;
      end

      // take ram data; shadowed writes or paced accesses go slow
      ST_CATCH: begin
        rdata_d = fram_rdata;
        if (then_slow_q) begin
          then_slow_d = 1'b0;
          state_d = ST_ALIGN;
        end else begin
          ready_d = 1'b1;
          state_d = ST_IDLE;
        end
      end

      // wait for the slow cycle to begin
      ST_ALIGN: begin
        if (tick) begin
          slow_req_d = drive_q;
          state_d = ST_SLOW;
        end
      end

      // slow cycle runs until the next tick
      ST_SLOW: begin
        if (tick) begin
          if (from_slow_q) rdata_d = slow_rdata_s;
          slow_req_d = 1'b0;
          drive_d = 1'b0;
          ready_d = 1'b1;
          state_d = ST_IDLE;
        end
      end

      // unused codes fall back to idle
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // running fast unless paced, waiting for a slow cycle or inside one
    speed_d = config_d[`CFG_SPEED_BIT]
              && (state_d != ST_ALIGN) && (state_d != ST_SLOW);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
      shadow_q <= `SHADOW_RESET;
      config_q <= `CONFIG_RESET;
      mirror_q <= `STATE_RESET;
      softsw_q <= '0;
      rdata_q <= 8'h00;
      ready_q <= 1'b0;
      fram_en_q <= 1'b0;
      fram_we_q <= 1'b0;
      fram_addr_q <= '0;
      fram_wdata_q <= 8'h00;
      slow_req_q <= 1'b0;
      slow_we_q <= 1'b0;
      slow_addr_q <= '0;
      slow_wdata_q <= 8'h00;
      then_slow_q <= 1'b0;
      drive_q <= 1'b0;
      from_slow_q <= 1'b0;
      phase_prev_q <= 1'b0;
      settle_q <= 2'd0;
      speed_q <= 1'b0;
    end else begin
      state_q <= state_d;
      shadow_q <= shadow_d;
      config_q <= config_d;
      mirror_q <= mirror_d;
      softsw_q <= softsw_d;
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      fram_en_q <= fram_en_d;
      fram_we_q <= fram_we_d;
      fram_addr_q <= fram_addr_d;
      fram_wdata_q <= fram_wdata_d;
      slow_req_q <= slow_req_d;
      slow_we_q <= slow_we_d;
      slow_addr_q <= slow_addr_d;
      slow_wdata_q <= slow_wdata_d;
      then_slow_q <= then_slow_d;
      drive_q <= drive_d;
      from_slow_q <= from_slow_d;
      phase_prev_q <= phase_prev_d;
      settle_q <= settle_d;
      speed_q <= speed_d;
    end
  end

  // outputs
  assign cpu_ready = ready_q;
  assign cpu_rdata = rdata_q;
  assign fram_en = fram_en_q;
  assign fram_we = fram_we_q;
  assign fram_addr = fram_addr_q;
  assign fram_wdata = fram_wdata_q;
  assign slow_req = slow_req_q;
  assign slow_we = slow_we_q;
  assign slow_addr = slow_addr_q;
  assign slow_wdata = slow_wdata_q;
  assign softsw_state = softsw_q;
  assign switch_state = mirror_q;
  assign fast_speed = speed_q;
endmodule

/* File: test/shadow_ctl_checker.sv */
// Purpose: port checks of fast_shadow_ctl
// Assumes: cpu holds each request until cpu_ready
// Notes: tracks the shadow register from completed writes
module shadow_ctl_checker
  import shadow_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // cpu
  input wire logic cpu_valid,
  input wire logic cpu_we,
  input wire logic [23:0] cpu_addr,
  input wire byte_t cpu_wdata,
  input wire logic cpu_ready,
  // ram, slow side, status
  input wire logic fram_en,
  input wire logic fram_we,
  input wire logic slow_req,
  input wire logic slow_we,
  input wire logic [16:0] slow_addr,
  input wire logic fast_speed,
  input wire byte_t switch_state
);
  timeunit 1ns;
  timeprecision 100ps;
  byte_t shd_q;
  byte_t shd_d;
  logic low;
  logic wr;
  logic st;
  assign low = cpu_addr[23:17] == 7'h00;
  assign wr = cpu_we && fast_speed;
  assign st = low && !shd_q[6] && cpu_addr[15:0] == 16'hc068;
  always_comb begin
    shd_d = shd_q;
    if (cpu_ready && cpu_we && low && !shd_q[6] &&
        cpu_addr[15:0] == 16'hc035)
      shd_d = cpu_wdata;
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      shd_q <= 8'h00;
    else
      shd_q <= shd_d;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence take;
    $rose(cpu_valid);
  endsequence
  sequence ram_only;
    ##1 !slow_req [*2] ##1 (cpu_ready && !slow_req);
  endsequence
  sequence slow_copy;
    ##[1:600] (slow_req && slow_we &&
      slow_addr == {cpu_addr[16], cpu_addr[15:0]});
  endsequence
  chk_reset_clear: assert property (
    $fell(reset) |-> !fast_speed && switch_state == 8'h00)
    else $error("outputs not clear after reset");
  chk_state_read: assert property (
    take ##0 (st && !cpu_we) |=> cpu_ready && !slow_req)
    else $error("state read not fast");
  chk_state_write: assert property (
    take ##0 (st && cpu_we) |=> !cpu_ready ##0 slow_copy)
    else $error("state write not forwarded");
  chk_shadow_copy: assert property (
    take ##0 (wr && low && cpu_addr[15:10] == 6'h01 && !shd_q[0])
    |=> fram_en && fram_we ##0 slow_copy)
    else $error("text write not duplicated");
  chk_text1_off: assert property (
    take ##0 (wr && low && cpu_addr[15:10] == 6'h01 && shd_q[0])
    |-> ram_only)
    else $error("inhibited text write went slow");
  chk_text2_never: assert property (
    take ##0 (wr && low && cpu_addr[15:10] == 6'h02) |-> ram_only)
    else $error("text page 2 write went slow");
  chk_aux_hires: assert property (
    take ##0 (wr && cpu_addr[23:16] == 8'h01 &&
      cpu_addr[15:13] == 3'h1 && shd_q[4]) |-> ram_only)
    else $error("aux hires write went slow");
  chk_read_fast: assert property (
    take ##0 (!cpu_we && fast_speed && low && cpu_addr[15:13] == 3'h1)
    |-> ram_only)
    else $error("shadowed read not fast");
  chk_slow_speed: assert property (
    slow_req |-> !fast_speed)
    else $error("fast during slow cycle");
  chk_ready_after: assert property (
    $fell(slow_req) |-> cpu_ready)
    else $error("stall beyond slow cycle");
endmodule

bind fast_shadow_ctl shadow_ctl_checker u_chk (
  .clk, .reset, .cpu_valid, .cpu_we, .cpu_addr, .cpu_wdata,
  .cpu_ready, .fram_en, .fram_we, .slow_req, .slow_we,
  .slow_addr, .fast_speed, .switch_state
);

/* File: test/slow_side_model.sv */
// Purpose: slow side holding i/o and video memory
// Assumes: one slow cycle per slow_req high period
// Notes: read data toggles outside read cycles
module slow_side_model
  import shadow_pkg::*;
#(
  parameter int HALF = 100
) (
  // clock
  input wire logic clk,
  // slow bus
  output logic slow_phase,
  input wire logic slow_req,
  input wire logic slow_we,
  input wire logic [16:0] slow_addr,
  input wire byte_t slow_wdata,
  output byte_t slow_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  byte_t smem [0:131071];
  int cnt;
  initial begin
    slow_phase = 1'b0;
    slow_rdata = 8'h00;
    cnt = 0;
    foreach (smem[i])
      smem[i] = 8'h00;
  end
  // free running 1 MHz phase, writes land at its rise
  always @(posedge clk) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) begin
      slow_phase <= !slow_phase;
      if (!slow_phase && slow_req && slow_we)
        smem[slow_addr] <= slow_wdata;
    end
    if (slow_req && !slow_we)
      slow_rdata <= smem[slow_addr];
    else
      slow_rdata <= ~slow_rdata;
  end
endmodule

/* File: test/fast_shadow_ctl_tb.sv */
// Purpose: directed test of fast_shadow_ctl
// Assumes: slow side runs at 1 MHz, fast ram is synchronous
// Notes: latency counted in negedges from request to ready
module fast_shadow_ctl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import shadow_pkg::*;
  typedef struct {
    byte_t cfg;
    byte_t shd;
    logic [23:0] adr;
    logic hit;
  } row_s;
  logic clk, reset, cpu_valid, cpu_we, cpu_ready, fram_en, fram_we;
  logic slow_phase, slow_req, slow_we, fast_speed, fram_held;
  logic [23:0] cpu_addr, fram_addr;
  logic [16:0] slow_addr;
  logic [6:0] softsw_state;
  byte_t cpu_wdata, cpu_rdata, fram_wdata, fram_rdata;
  byte_t slow_wdata, slow_rdata, switch_state, rq;
  byte_t fmem [logic [23:0]];
  int bad_count, check_count, lat;
  row_s rows [13] = '{
    '{8'h80, 8'h00, 24'h00_0400, 1'b1},
    '{8'h80, 8'h01, 24'h00_0410, 1'b0},
    '{8'h80, 8'h00, 24'h00_0800, 1'b0},
    '{8'h80, 8'h00, 24'h01_2000, 1'b1},
    '{8'h80, 8'h02, 24'h00_2010, 1'b0},
    '{8'h80, 8'h04, 24'h00_4000, 1'b0},
    '{8'h80, 8'h00, 24'h01_4010, 1'b1},
    '{8'h80, 8'h10, 24'h01_2020, 1'b0},
    '{8'h80, 8'h10, 24'h00_2020, 1'b1},
    '{8'h80, 8'h08, 24'h00_6000, 1'b0},
    '{8'h80, 8'h00, 24'h02_0408, 1'b0},
    '{8'h90, 8'h00, 24'h02_0404, 1'b1},
    '{8'h90, 8'h00, 24'h7f_040c, 1'b1}
  };
  fast_shadow_ctl u_dut (
    .clk, .reset, .cpu_valid, .cpu_we, .cpu_addr, .cpu_wdata,
    .cpu_ready, .cpu_rdata, .fram_en, .fram_we, .fram_addr,
    .fram_wdata, .fram_rdata, .slow_phase, .slow_req, .slow_we,
    .slow_addr, .slow_wdata, .slow_rdata, .fast_speed,
    .softsw_state, .switch_state
  );
  slow_side_model u_slow (
    .clk, .slow_phase, .slow_req, .slow_we, .slow_addr,
    .slow_wdata, .slow_rdata
  );
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(negedge clk) begin
    if (fram_en === 1'b1 && fram_we === 1'b1)
      fmem[fram_addr] = fram_wdata;
    if (fram_en === 1'b1)
      fram_rdata <= fmem.exists(fram_addr) ? fmem[fram_addr] : 8'h00;
    else if (!fram_held)
      fram_rdata <= ~fram_rdata;
    fram_held <= (fram_en === 1'b1);
  end
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk8(input byte_t got, input byte_t exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: byte %h not %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic ok);
    check_count++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("Error %0t: condition false", $time);
    end
  endtask
  task automatic acc(input logic we, input logic [23:0] a, input byte_t d);
    @(negedge clk);
    cpu_valid = 1'b1;
    cpu_we = we;
    cpu_addr = a;
    cpu_wdata = d;
    for (lat = 1; lat < 2000; lat++) begin
      @(negedge clk);
      if (cpu_ready === 1'b1)
        break;
    end
    if (lat == 2000) begin
      bad_count++;
      test_done();
    end
    rq = cpu_rdata;
    cpu_valid = 1'b0;
  endtask
  initial begin
    byte_t d;
    logic [16:0] sa;
    reset = 1'b1;
    cpu_valid = 1'b0;
    cpu_we = 1'b0;
    cpu_addr = 24'h00_0000;
    cpu_wdata = 8'h00;
    fram_rdata = 8'h00;
    fram_held = 1'b0;
    bad_count = 0;
    check_count = 0;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    acc(0, 24'h00_c035, 8'h00);
    chk8(rq, 8'h00);
    acc(0, 24'h00_c036, 8'h00);
    chk8(rq, 8'h00);
    chkb(fast_speed === 1'b0);
    acc(1, 24'h00_c036, 8'h80);
    chkb(fast_speed === 1'b1);
    acc(1, 24'h00_c068, 8'h5a);
    chkb(lat > 2);
    chk8(u_slow.smem[17'h0_c068], 8'h5a);
    chk8(switch_state, 8'h5a);
    acc(0, 24'h00_c068, 8'h00);
    chk8(rq, 8'h5a);
    chkb(lat == 1);
    acc(1, 24'h00_c068, 8'h00);
    acc(1, 24'h00_c001, 8'h00);
    chkb(softsw_state[0] === 1'b1);
    u_slow.smem[17'h0_c001] = 8'h3c;
    acc(0, 24'h00_c001, 8'h00);
    chk8(rq, 8'h3c);
    acc(1, 24'h00_c000, 8'h00);
    chkb(softsw_state[0] === 1'b0);
    acc(1, 24'he1_0600, 8'h33);
    chk8(u_slow.smem[17'h1_0600], 8'h33);
    acc(0, 24'he1_0600, 8'h00);
    chk8(rq, 8'h33);
    chkb(lat > 4);
    foreach (rows[i]) begin
      acc(1, 24'h00_c036, rows[i].cfg);
      acc(1, 24'h00_c035, rows[i].shd);
      sa = {rows[i].adr[16], rows[i].adr[15:0]};
      d = 8'h20 + 8'(i);
      acc(1, rows[i].adr, d);
      chkb(rows[i].hit ? lat > 4 : lat == 3);
      chk8(u_slow.smem[sa], rows[i].hit ? d : 8'h00);
      acc(0, rows[i].adr, 8'h00);
      chk8(rq, d);
      chkb(lat == 3);
    end
    acc(1, 24'h00_c035, 8'h5f);
    acc(1, 24'h00_0400, 8'h61);
    chkb(lat == 3);
    chk8(u_slow.smem[17'h0_0400], 8'h20);
    acc(1, 24'h00_c035, 8'h77);
    acc(0, 24'h00_c035, 8'h00);
    chk8(rq, 8'h77);
    chkb(lat == 3);
    acc(1, 24'h00_c003, 8'h00);
    chkb(softsw_state[1] === 1'b0);
    @(negedge clk);
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    acc(0, 24'h00_c035, 8'h00);
    chk8(rq, 8'h00);
    acc(0, 24'h00_c036, 8'h00);
    chk8(rq, 8'h00);
    test_done();
  end
endmodule
